/* hw/fupc_top.sv */
// flash user program sequencer: key, control, sector registers, timing
// assumes irq_request and sub_clock_sel come from logic on sys_clk
`timescale 1ns/100ps
`include "fupc_regs.svh"
module fupc_top #(
  parameter int ERASE_CYCLES = `FUPC_ERASE_CYCLES,
  parameter int LOCK_CYCLES = `FUPC_LOCK_CYCLES,
  parameter int PROG_CYCLES = `FUPC_PROG_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // cpu program-memory access
  input wire logic pm_valid,
  input wire fupc_pkg::fupc_pm_req_type pm_req,
  output logic pm_ready,
  output logic pm_done,
  output logic pm_err,
  output logic [7:0] pm_rdata,
  // system status
  input wire logic irq_request,
  input wire logic sub_clock_sel,
  output logic user_mode,
  // flash array
  output logic fl_erase,
  output logic fl_lock,
  output logic fl_prog,
  output logic [15:0] fl_addr,
  output logic [7:0] fl_wdata,
  input wire logic [7:0] fl_rdata
);

////////////////////////////////////////////////////////////////////////
// reset release

logic rst_meta_n;
logic rst_sync_n;

always_ff @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    rst_meta_n <= 1'b0;
    rst_sync_n <= 1'b0;
  end
  else
  begin
    rst_meta_n <= 1'b1;
    rst_sync_n <= rst_meta_n;
  end
end

////////////////////////////////////////////////////////////////////////
// register decode

function automatic logic [3:0] fupc_dec(input logic [7:0] a);
  case (a)
    `FUPC_OFS_CTRL: fupc_dec = 4'h1;
    `FUPC_OFS_KEY: fupc_dec = 4'h2;
    `FUPC_OFS_SECH: fupc_dec = 4'h4;
    `FUPC_OFS_SECL: fupc_dec = 4'h8;
    default: fupc_dec = 4'h0;
  endcase
endfunction

fupc_pkg::fupc_state_type st;
fupc_pkg::fupc_state_type next_st;
logic [7:0] key;
logic [3:0] mode;
logic status;
logic [7:0] sech;
logic secl7;
logic [7:0] prog_n;
logic [31:0] cnt;
logic [31:0] next_cnt;
logic aw_hold;
logic w_hold;
logic [7:0] aw_addr;
logic [7:0] w_byte;
logic w_lane;

logic mode_en;
logic wr_do;
logic [3:0] wr_sel;
logic [3:0] rd_sel;
logic ctrl_wr;
logic start;
logic erase_go;
logic lock_go;
logic is_idle;
logic pm_take;
logic pm_match;
logic pm_wr_ok;
logic op_last;
logic [31:0] last_cnt;
logic [15:0] sector_base;
logic [7:0] ctrl_rd;
logic [7:0] rd_byte;

// irq and sub clock share sys_clk, so no synchroniser is needed
assign mode_en = (key == `FUPC_KEY_OPEN) && !sub_clock_sel;
assign user_mode = mode_en;
assign wr_do = aw_hold && w_hold && !s_axi_bvalid;
assign wr_sel = fupc_dec(aw_addr);
assign rd_sel = fupc_dec(s_axi_araddr);
assign is_idle = (st == fupc_pkg::ST_IDLE);
// control writes are dropped outside user mode; no read-protect field
assign ctrl_wr = wr_do && wr_sel[0] && w_lane && mode_en;
assign start = ctrl_wr && w_byte[`FUPC_BIT_START] && is_idle;
assign erase_go = start && (w_byte[7:4] == `FUPC_MODE_ERASE);
assign lock_go = start && (w_byte[7:4] == `FUPC_MODE_LOCK);
assign sector_base = {sech, secl7, 7'h00};
assign pm_ready = is_idle && !erase_go && !lock_go;
assign pm_take = pm_valid && pm_ready;
assign pm_match = (pm_req.addr[15:7] == sector_base[15:7]);
assign pm_wr_ok = mode_en && (mode == `FUPC_MODE_PROG) && pm_match
  && (prog_n < `FUPC_SECTOR_BYTES) && !irq_request;
assign last_cnt = (st == fupc_pkg::ST_ERASE) ? 32'(ERASE_CYCLES - 1)
  : (st == fupc_pkg::ST_LOCK) ? 32'(LOCK_CYCLES - 1)
  : 32'(PROG_CYCLES - 1);
assign op_last = (cnt == last_cnt);
assign fl_erase = (st == fupc_pkg::ST_ERASE);
assign fl_lock = (st == fupc_pkg::ST_LOCK);
assign fl_prog = (st == fupc_pkg::ST_PROG);
assign ctrl_rd = mode_en ? {mode, status, 2'h0, !is_idle}
  : {4'h0, status, 3'h0};
assign rd_byte = rd_sel[0] ? ctrl_rd : rd_sel[1] ? key
  : rd_sel[2] ? sech : rd_sel[3] ? {secl7, 7'h00} : 8'h00;
assign s_axi_awready = !aw_hold && !s_axi_bvalid;
assign s_axi_wready = !w_hold && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

////////////////////////////////////////////////////////////////////////
// bus slave

always_ff @(posedge sys_clk or negedge rst_sync_n)
begin
  if (!rst_sync_n)
  begin
    aw_hold <= 1'b0;
    w_hold <= 1'b0;
    aw_addr <= 8'h00;
    w_byte <= 8'h00;
    w_lane <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `FUPC_RESP_OKAY;
  end
  else
  begin
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane <= s_axi_wstrb[0];
    end
    if (wr_do)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel == 4'h0) ? `FUPC_RESP_SLVERR
        : `FUPC_RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
end

always_ff @(posedge sys_clk or negedge rst_sync_n)
begin
  if (!rst_sync_n)
  begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h0000_0000;
    s_axi_rresp <= `FUPC_RESP_OKAY;
  end
  else if (s_axi_arvalid && s_axi_arready)
  begin
    s_axi_rvalid <= 1'b1;
    s_axi_rdata <= {24'h00_0000, rd_byte};
    s_axi_rresp <= (rd_sel == 4'h0) ? `FUPC_RESP_SLVERR
      : `FUPC_RESP_OKAY;
  end
  else if (s_axi_rready)
    s_axi_rvalid <= 1'b0;
end

////////////////////////////////////////////////////////////////////////
// registers

always_ff @(posedge sys_clk or negedge rst_sync_n)
begin
  if (!rst_sync_n)
  begin
    key <= `FUPC_KEY_RESET;
    mode <= 4'h0;
    status <= 1'b0;
    sech <= 8'h00;
    secl7 <= 1'b0;
    prog_n <= 8'h00;
  end
  else
  begin
    // a pending interrupt wins over a key write: the mode must stop
    if (irq_request)
      key <= `FUPC_KEY_RESET;
    else if (wr_do && wr_sel[1] && w_lane)
      key <= w_byte;
    if (ctrl_wr)
      mode <= w_byte[7:4];
    if (st == fupc_pkg::ST_ERASE && irq_request)
      status <= 1'b1;
    else if (erase_go)
      status <= 1'b0;
    if (wr_do && wr_sel[2] && w_lane)
      sech <= w_byte;
    if (wr_do && wr_sel[3] && w_lane)
      secl7 <= w_byte[7];
    if (wr_do && (wr_sel[2] || wr_sel[3]) && w_lane)
      prog_n <= 8'h00;
    else if (pm_take && pm_req.write && pm_wr_ok)
      prog_n <= prog_n + 8'h01;
  end
end

////////////////////////////////////////////////////////////////////////
// sequencer

always_comb
begin
  next_st = st;
  next_cnt = cnt + 32'h1;
  case (st)
    fupc_pkg::ST_IDLE:
    begin
      next_cnt = 32'h0;
      if (erase_go)
        next_st = fupc_pkg::ST_ERASE;
      else if (lock_go)
        next_st = fupc_pkg::ST_LOCK;
      else if (pm_take && !pm_req.write)
        next_st = fupc_pkg::ST_READ;
      else if (pm_take && pm_wr_ok)
        next_st = fupc_pkg::ST_PROG;
    end
    fupc_pkg::ST_ERASE, fupc_pkg::ST_LOCK, fupc_pkg::ST_PROG:
    begin
      if (irq_request || op_last)
        next_st = fupc_pkg::ST_IDLE;
    end
    fupc_pkg::ST_READ:
      next_st = fupc_pkg::ST_IDLE;
    default:
      next_st = fupc_pkg::ST_IDLE;
  endcase
end

always_ff @(posedge sys_clk or negedge rst_sync_n)
begin
  if (!rst_sync_n)
  begin
    st <= fupc_pkg::ST_IDLE;
    cnt <= 32'h0;
  end
  else
  begin
    st <= next_st;
    cnt <= next_cnt;
  end
end

always_ff @(posedge sys_clk or negedge rst_sync_n)
begin
  if (!rst_sync_n)
  begin
    fl_addr <= 16'h0000;
    fl_wdata <= 8'h00;
    pm_done <= 1'b0;
    pm_err <= 1'b0;
    pm_rdata <= 8'h00;
  end
  else
  begin
    pm_done <= 1'b0;
    pm_err <= 1'b0;
    if (erase_go || lock_go)
      fl_addr <= sector_base;
    else if (pm_take)
    begin
      fl_addr <= pm_req.addr;
      fl_wdata <= pm_req.wdata;
    end
    if (pm_take && pm_req.write && !pm_wr_ok)
    begin
      pm_done <= 1'b1;
      pm_err <= 1'b1;
    end
    if (st == fupc_pkg::ST_READ)
    begin
      pm_done <= 1'b1;
      pm_rdata <= fl_rdata;
    end
    if (st == fupc_pkg::ST_PROG && (irq_request || op_last))
    begin
      pm_done <= 1'b1;
      pm_err <= irq_request;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// checks

key_reject_a: assert property (@(posedge sys_clk)
  disable iff (!rst_sync_n)
  (key != `FUPC_KEY_OPEN) |-> !user_mode)
  else $error("user mode without key");
irq_stop_a: assert property (@(posedge sys_clk)
  disable iff (!rst_sync_n)
  irq_request |=> !user_mode)
  else $error("user mode kept after irq");
sub_clk_a: assert property (@(posedge sys_clk)
  disable iff (!rst_sync_n)
  sub_clock_sel |-> !user_mode)
  else $error("user mode on sub clock");
erase_abort_a: assert property (@(posedge sys_clk)
  disable iff (!rst_sync_n)
  (fl_erase && irq_request) |=> (!fl_erase && status))
  else $error("erase not aborted with failure");
erase_start_a: assert property (@(posedge sys_clk)
  disable iff (!rst_sync_n)
  erase_go |=> (fl_erase && !status && fl_addr == sector_base))
  else $error("erase did not start clean");
erase_len_a: assert property (@(posedge sys_clk)
  disable iff (!rst_sync_n)
  ($fell(fl_erase) && !status) |-> ($past(cnt) == 32'(ERASE_CYCLES - 1)))
  else $error("erase ended early");
ctrl_lock_a: assert property (@(posedge sys_clk)
  disable iff (!rst_sync_n)
  (wr_do && wr_sel[0] && !mode_en) |=> $stable(mode)
    && !$rose(fl_erase) && !$rose(fl_lock))
  else $error("control written outside user mode");
prog_limit_a: assert property (@(posedge sys_clk)
  disable iff (!rst_sync_n)
  $rose(fl_prog) |-> ($past(prog_n) < `FUPC_SECTOR_BYTES
    && fl_addr[15:7] == sector_base[15:7]))
  else $error("program outside sector or over limit");
read_lat_a: assert property (@(posedge sys_clk)
  disable iff (!rst_sync_n)
  (pm_take && !pm_req.write) |=> ##1 (pm_done && !pm_err))
  else $error("byte read not answered in two cycles");
erase_done_c: cover property (@(posedge sys_clk)
  disable iff (!rst_sync_n) $fell(fl_erase) && !status);
erase_abort_c: cover property (@(posedge sys_clk)
  disable iff (!rst_sync_n) fl_erase && irq_request);
prog_ok_c: cover property (@(posedge sys_clk)
  disable iff (!rst_sync_n) fl_prog ##1 pm_done && !pm_err);
lock_c: cover property (@(posedge sys_clk)
  disable iff (!rst_sync_n) $fell(fl_lock));

endmodule

/* hw/fupc_regs.svh */
// register map, field positions and timing counts of the flash sequencer
// assumes a 20 MHz sys_clk and byte-wide registers in the low data lane
// Operation
// - mode enabled only with key A5
// - reset clears unlock key to zero
// - any other key disables mode at once
// - control bit 0 starts erase or lock
// - byte read and program need no start
// - read-only erase status, one means failed
// - interrupt aborts erase, status reports failure
// - any interrupt request stops user mode
// - no user mode on sub-system clock
// - control register works only in user mode
// - 512 sectors of 128 bytes; sech and secl bit 7 select one of 512 sectors of 128 bytes
// - low sector bits 6-0 ignored
// - high and low registers form sector base
// - read protection never set from here
// - erase lasts at least 10 ms
// - at most 128 bytes per sector load
`ifndef FUPC_REGS_SVH
`define FUPC_REGS_SVH
`define FUPC_OFS_CTRL 8'h00
`define FUPC_OFS_KEY 8'h04
`define FUPC_OFS_SECH 8'h08
`define FUPC_OFS_SECL 8'h0C
`define FUPC_KEY_OPEN 8'hA5
`define FUPC_KEY_RESET 8'h00
`define FUPC_BIT_START 0
`define FUPC_BIT_STATUS 3
`define FUPC_MODE_ERASE 4'hA
`define FUPC_MODE_PROG 4'h5
`define FUPC_MODE_LOCK 4'h6
`define FUPC_SECTOR_BYTES 8'h80
`define FUPC_CLK_HZ 20000000
`define FUPC_ERASE_MS 10
`define FUPC_ERASE_CYCLES (`FUPC_ERASE_MS * (`FUPC_CLK_HZ / 1000))
`define FUPC_LOCK_CYCLES 16
`define FUPC_PROG_CYCLES 4
`define FUPC_RESP_OKAY 2'h0
`define FUPC_RESP_SLVERR 2'h2
`endif

/* hw/fupc_pkg.sv */
// types shared by the flash sequencer
// assumes fupc_regs.svh for the numeric constants
package fupc_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ERASE = 5'h02,
    ST_LOCK = 5'h04,
    ST_PROG = 5'h08,
    ST_READ = 5'h10
  } fupc_state_type;
  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fupc_pm_req_type;
endpackage

/* test/fupc_flash_model.sv */
// flash array stand-in: erase fills a sector with FF, program writes a byte
// assumes only the low 8 address bits matter in this small copy
`timescale 1ns/100ps
module fupc_flash_model (
  // clock
  input wire logic sys_clk,
  // array control
  input wire logic fl_erase,
  input wire logic fl_prog,
  input wire logic [15:0] fl_addr,
  input wire logic [7:0] fl_wdata,
  // read data
  output logic [7:0] fl_rdata
);
  logic [7:0] mem [0:255];
  always @(posedge sys_clk)
  begin
    if (fl_erase)
      for (int i = 0; i < 128; i++)
        mem[{fl_addr[7], i[6:0]}] <= 8'hFF;
    else if (fl_prog)
      mem[fl_addr[7:0]] <= fl_wdata;
  end
  assign fl_rdata = mem[fl_addr[7:0]];
endmodule

/* test/tb.sv */
// bench for the flash sequencer: bus, key, erase, program, lock, abort
// assumes fupc_regs.svh on the include path and the array stand-in
`timescale 1ns/100ps
`include "fupc_regs.svh"
module tb;
  localparam int ECYC = 20;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pm_ready, pm_done, pm_err, user_mode;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd_q;
  logic pm_valid = 1'h0, irq_request = 1'h0, sub_clock_sel = 1'h0;
  fupc_pkg::fupc_pm_req_type pm_req = '0;
  logic [7:0] pm_rdata, fl_wdata, fl_rdata, pm_q;
  logic fl_erase, fl_lock, fl_prog, pm_e;
  logic [15:0] fl_addr;
  int fail_count = 0;
  int checks = 0;
  fupc_top #(.ERASE_CYCLES(ECYC)) fupc_top_inst (
    .sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pm_valid, .pm_req, .pm_ready, .pm_done, .pm_err, .pm_rdata, .irq_request,
    .sub_clock_sel, .user_mode, .fl_erase, .fl_lock, .fl_prog, .fl_addr,
    .fl_wdata, .fl_rdata);
  fupc_flash_model fupc_flash_model_inst (
    .sys_clk, .fl_erase, .fl_prog, .fl_addr, .fl_wdata, .fl_rdata);
  always #25 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // handshakes are judged at the falling edge, where they are settled
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    logic ka, kw, kb;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    repeat (50)
    begin
      @(negedge sys_clk);
      ka = s_axi_awvalid & s_axi_awready;
      kw = s_axi_wvalid & s_axi_wready;
      kb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge sys_clk);
      if (ka)
        s_axi_awvalid <= 1'h0;
      if (kw)
        s_axi_wvalid <= 1'h0;
      if (kb)
        s_axi_bready <= 1'h0;
      if (kb)
        break;
    end
    cmp("write answer", 32'h1, {31'h0, kb});
  endtask
  task automatic axr(input logic [7:0] a);
    logic ka, kr;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    repeat (50)
    begin
      @(negedge sys_clk);
      ka = s_axi_arvalid & s_axi_arready;
      kr = s_axi_rvalid;
      rd_q = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge sys_clk);
      if (ka)
        s_axi_arvalid <= 1'h0;
      if (kr)
        s_axi_rready <= 1'h0;
      if (kr)
        break;
    end
    cmp("read answer", 32'h1, {31'h0, kr});
  endtask
  task automatic pmx(input logic w, input logic [15:0] a, input logic [7:0] d);
    logic kd;
    @(posedge sys_clk);
    pm_req <= '{write: w, addr: a, wdata: d};
    pm_valid <= 1'h1;
    repeat (50)
    begin
      @(negedge sys_clk);
      kd = pm_valid & pm_ready;
      if (pm_done)
        break;
      @(posedge sys_clk);
      if (kd)
        pm_valid <= 1'h0;
    end
    cmp("pm answer", 32'h1, {31'h0, pm_done});
    pm_e = pm_err;
    pm_q = pm_rdata;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    axr(`FUPC_OFS_KEY);
    cmp("key", 32'h0, rd_q);
    axw(`FUPC_OFS_CTRL, 8'hA1);
    @(negedge sys_clk);
    cmp("erase locked", 32'h0, {31'h0, fl_erase});
    s_axi_wstrb <= 4'h0;
    axw(`FUPC_OFS_KEY, `FUPC_KEY_OPEN);
    s_axi_wstrb <= 4'hF;
    @(negedge sys_clk);
    cmp("no strobe", 32'h0, {31'h0, user_mode});
    axr(8'h10);
    cmp("unmapped", {30'h0, `FUPC_RESP_SLVERR}, {30'h0, resp});
    axw(8'h10, 8'h00);
    cmp("unmapped write", {30'h0, `FUPC_RESP_SLVERR}, {30'h0, resp});
  endtask
  task automatic t_abort();
    axw(`FUPC_OFS_KEY, `FUPC_KEY_OPEN);
    cmp("key write", {30'h0, `FUPC_RESP_OKAY}, {30'h0, resp});
    axw(`FUPC_OFS_SECH, 8'h10);
    axw(`FUPC_OFS_SECL, 8'hFF);
    axw(`FUPC_OFS_CTRL, 8'hA1);
    @(negedge sys_clk);
    cmp("erase on", 32'h1, {31'h0, fl_erase});
    cmp("erase addr", 32'h1080, {16'h0, fl_addr});
    @(posedge sys_clk);
    irq_request <= 1'h1;
    @(posedge sys_clk);
    irq_request <= 1'h0;
    @(negedge sys_clk);
    cmp("erase stop", 32'h0, {31'h0, fl_erase});
    cmp("irq mode", 32'h0, {31'h0, user_mode});
    axr(`FUPC_OFS_CTRL);
    cmp("fail flag", 32'h08, rd_q);
  endtask
  task automatic t_erase();
    int n;
    n = 0;
    axw(`FUPC_OFS_KEY, `FUPC_KEY_OPEN);
    axw(`FUPC_OFS_CTRL, 8'hA1);
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (fl_erase === 1'h1 && n < 100);
    // one erase cycle already passed inside the write task
    cmp("erase time", ECYC, n);
    axr(`FUPC_OFS_CTRL);
    cmp("status ok", 32'h0, rd_q & 32'h09);
  endtask
  task automatic t_prog();
    axw(`FUPC_OFS_CTRL, 8'h51);
    for (int i = 0; i < 128; i++)
    begin
      pmx(1'h1, 16'h1080 + 16'(i), 8'(i));
      cmp("prog", 32'h0, {31'h0, pm_e});
    end
    pmx(1'h1, 16'h1080, 8'h00);
    cmp("over count", 32'h1, {31'h0, pm_e});
    pmx(1'h0, 16'h1085, 8'h00);
    cmp("read back", 32'h05, {24'h0, pm_q});
    axw(`FUPC_OFS_SECL, 8'h80);
    pmx(1'h1, 16'h1105, 8'h11);
    cmp("other sector", 32'h1, {31'h0, pm_e});
  endtask
  task automatic t_lock();
    int n;
    n = 0;
    axw(`FUPC_OFS_CTRL, 8'h61);
    @(negedge sys_clk);
    cmp("lock on", 32'h1, {31'h0, fl_lock});
    while (fl_lock === 1'h1 && n < 100)
    begin
      @(negedge sys_clk);
      n++;
    end
    // two lock cycles passed before the loop, the last one counts low
    cmp("lock time", `FUPC_LOCK_CYCLES - 1, n);
    axw(`FUPC_OFS_KEY, 8'h5A);
    @(negedge sys_clk);
    cmp("other key", 32'h0, {31'h0, user_mode});
    axw(`FUPC_OFS_KEY, `FUPC_KEY_OPEN);
    @(negedge sys_clk);
    cmp("key reopen", 32'h1, {31'h0, user_mode});
    @(posedge sys_clk);
    sub_clock_sel <= 1'h1;
    @(negedge sys_clk);
    cmp("sub clock", 32'h0, {31'h0, user_mode});
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_abort();
    t_erase();
    t_prog();
    t_lock();
    end_of_test();
  end
  // the run needs about 900 cycles; this allows over five times that
  initial
  begin
    #(5000 * 50);
    fail_count++;
    end_of_test();
  end
endmodule
